// *** logic/clock_gate_consts.svh ***
// Offsets, field positions and reset values of the module clock-gate bank.
`ifndef CLOCK_GATE_CONSTS_SVH
`define CLOCK_GATE_CONSTS_SVH
`define ANALOG_BLOCK_DISABLE_OFS    16'hF240
`define COMPARATOR_DISABLE_OFS      16'hF250
`define CAPTURE_COMPARE_DISABLE_OFS 16'hF260
`define TIMER_DISABLE_OFS           16'hF270
`define SERIAL_PORT_DISABLE_OFS     16'hF280
`define MISC_MODULE_DISABLE_OFS     16'hF290
`define CONFIG_CONTROL_REG_OFS      16'hF200
`define ALIAS_CLR_OFS               4'h4
`define ALIAS_SET_OFS               4'h8
`define ALIAS_INV_OFS               4'hC
`define LOCK_BIT_POS                12
`define ONE_WAY_BIT_POS             28
`define DISABLE_RESET               32'h00000000
`define ANALOG_BLOCK_MASK           32'h00001101
`define COMPARATOR_MASK             32'h00000007
`define CAPTURE_COMPARE_MASK        32'h001F001F
`define TIMER_MASK                  32'h0000001F
`define SERIAL_PORT_MASK            32'h01030303
`define MISC_MODULE_MASK            32'h00010003
`define UNMAPPED_READ               32'h00000000
`endif

// *** logic/clock_gate_pkg.sv ***
// Types shared by the module clock-gate bank.
package clock_gate_pkg;
  typedef enum logic [1:0] {
    ALIAS_WRITE,
    ALIAS_CLR,
    ALIAS_SET,
    ALIAS_INV
  } alias_op_t;
endpackage : clock_gate_pkg

// *** logic/disable_reg.sv ***
// One module disable register with write, clear, set and invert aliases.
`timescale 1ns/1ps
`default_nettype none
`include "clock_gate_consts.svh"
module disable_reg
  import clock_gate_pkg::*;
#(
  parameter logic [31:0] IMPL_MASK = 32'hFFFFFFFF
) (
  input  wire logic        clk,      // Bus clock.
  input  wire logic        rst,      // Synchronous reset, active high.
  input  wire logic        wr_en,    // Accepted write to this register.
  input  wire alias_op_t   op,       // Which alias was written.
  input  wire logic [31:0] wdata,    // Write data.
  output logic      [31:0] value_ff  // Stored disable bits.
);
  logic [31:0] nxt_value;

  always_comb begin
    unique case (op)
      ALIAS_WRITE: nxt_value = wdata;
      ALIAS_CLR:   nxt_value = value_ff & ~wdata;
      ALIAS_SET:   nxt_value = value_ff | wdata;
      ALIAS_INV:   nxt_value = value_ff ^ wdata;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      value_ff <= `DISABLE_RESET;
    end else if (wr_en) begin
      value_ff <= nxt_value & IMPL_MASK;
    end
  end
endmodule : disable_reg
`default_nettype wire

// *** logic/clock_gate_bank.sv ***
// Module clock-gate bank: six disable registers behind an Avalon-MM slave with a write lock.
`timescale 1ns/1ps
`default_nettype none
`include "clock_gate_consts.svh"
// How it works
// - With the one-way configuration bit programmed, the lock bit cannot be cleared once set.
// - While the lock bit is set, writes to the disable registers and pin-select lock leave them unchanged.
// - Only a device reset clears a lock bit held by the one-way setting.
// - Each disable register has clear, set and invert aliases at offsets 0x4, 0x8 and 0xC.
// - Unimplemented bits read zero and every register resets to zero.
// - A disable bit of one stops that module's clock, zero enables it.
// - The lock bit at position 12 of the control register blocks disable-register writes.
// - A disabled module's own registers ignore writes and return meaningless reads.
module clock_gate_bank
  import clock_gate_pkg::*;
(
  input  wire logic         clk,                   // 100 MHz bus clock.
  input  wire logic         rst,                   // Synchronous device reset, active high.
  input  wire logic         config_word_three_in,  // One-way config bit from fused word three.
  input  wire logic [15:0]  address,               // Avalon byte address.
  input  wire logic         read,                  // Avalon read.
  input  wire logic         write,                 // Avalon write.
  input  wire logic [31:0]  writedata,             // Avalon write data.
  input  wire logic [3:0]   byteenable,            // Avalon byte enables.
  output logic      [31:0]  readdata,              // Avalon read data.
  output logic              waitrequest,           // Avalon wait request.
  output logic      [191:0] module_clock_stop_bit, // Clock stop per module, six words.
  output logic              disable_bank_write_lock // Lock state, also gates pin select.
);
  localparam int NREG = 6;
  localparam logic [31:0] MASKS [NREG] = '{`ANALOG_BLOCK_MASK, `COMPARATOR_MASK,
    `CAPTURE_COMPARE_MASK, `TIMER_MASK, `SERIAL_PORT_MASK, `MISC_MODULE_MASK};
  localparam logic [15:0] BASES [NREG] = '{`ANALOG_BLOCK_DISABLE_OFS, `COMPARATOR_DISABLE_OFS,
    `CAPTURE_COMPARE_DISABLE_OFS, `TIMER_DISABLE_OFS, `SERIAL_PORT_DISABLE_OFS,
    `MISC_MODULE_DISABLE_OFS};

  logic        one_way_meta_ff;
  logic        single_session_lock_cfg_ff;
  logic        lock_ff;
  logic        was_locked_ff;
  logic        busy_ff;
  logic [31:0] regs [NREG];
  logic [31:0] bemask;
  logic        req;
  logic        take;
  logic        wr_done;
  logic        lock_hold;
  alias_op_t   op_sel;

  // Expands byte enables into a bit mask.
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  // Maps the low nibble of an address onto the alias it selects.
  function automatic alias_op_t alias_of(input logic [3:0] lo);
    unique case (lo)
      `ALIAS_CLR_OFS: alias_of = ALIAS_CLR;
      `ALIAS_SET_OFS: alias_of = ALIAS_SET;
      `ALIAS_INV_OFS: alias_of = ALIAS_INV;
      default:        alias_of = ALIAS_WRITE;
    endcase
  endfunction : alias_of

  // True when a word-aligned address falls in the 16-byte window of one disable register.
  function automatic logic in_window(input logic [15:0] a, input logic [15:0] base);
    in_window = (a[15:4] == base[15:4]) && (a[1:0] == 2'b00);
  endfunction : in_window

  // Plain writes keep the bytes of disabled lanes; aliases act on enabled lanes only.
  function automatic logic [31:0] lane_data(input alias_op_t op, input logic [31:0] d,
                                            input logic [31:0] old, input logic [31:0] m);
    if (op == ALIAS_WRITE) begin
      lane_data = (d & m) | (old & ~m);
    end else begin
      lane_data = d & m;
    end
  endfunction : lane_data

  // Readback word of the control register: only the lock bit is implemented.
  function automatic logic [31:0] ctrl_word(input logic lock);
    ctrl_word                = `UNMAPPED_READ;
    ctrl_word[`LOCK_BIT_POS] = lock;
  endfunction : ctrl_word

  assign bemask  = lane_mask(byteenable);
  assign req     = (read | write) & waitrequest;
  // A strobe still held in the ack cycle is not taken again, since req needs waitrequest high there.
  assign take    = req && !busy_ff;
  // Writes land at the edge where the master samples waitrequest low, never earlier.
  assign wr_done = write && !waitrequest;
  assign op_sel  = alias_of(address[3:0]);

  // Fuse strap is a level from outside this domain; two flops before use.
  always_ff @(posedge clk) begin
    if (rst) begin
      one_way_meta_ff            <= 1'b0;
      single_session_lock_cfg_ff <= 1'b0;
    end else begin
      one_way_meta_ff            <= config_word_three_in;
      single_session_lock_cfg_ff <= one_way_meta_ff;
    end
  end

  // One wait cycle then a one-cycle acknowledge; locked writes are acked just the same.
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_ff     <= 1'b0;
      waitrequest <= 1'b1;
    end else if (take) begin
      busy_ff     <= 1'b1;
      waitrequest <= 1'b0;
    end else begin
      busy_ff     <= 1'b0;
      waitrequest <= 1'b1;
    end
  end

  logic cfg_sel;
  logic cfg_wr;
  logic nxt_lock;
  assign cfg_sel = (address == `CONFIG_CONTROL_REG_OFS);
  assign cfg_wr    = wr_done && cfg_sel && byteenable[1];
  // Once the lock has ever been set it can no longer be cleared while the synchronized one-way strap is high.
  assign lock_hold = single_session_lock_cfg_ff && was_locked_ff;

  always_comb begin
    nxt_lock = lock_ff;
    if (cfg_wr) begin
      nxt_lock = writedata[`LOCK_BIT_POS];
      if (lock_hold) begin
        nxt_lock = 1'b1;
      end
    end
  end

  // The one-way history falls only under device reset; the lock also falls on a control write of zero while not held.
  always_ff @(posedge clk) begin
    if (rst) begin
      lock_ff       <= 1'b0;
      was_locked_ff <= 1'b0;
    end else begin
      lock_ff       <= nxt_lock;
      was_locked_ff <= was_locked_ff | nxt_lock;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      logic hit;
      logic wr;
      logic [31:0] wd;
      assign hit = in_window(address, BASES[g]);
      // A locked write is swallowed here and still acknowledged.
      assign wr  = wr_done && hit && !lock_ff;
      assign wd  = lane_data(op_sel, writedata, regs[g], bemask);
      disable_reg #(
        .IMPL_MASK(MASKS[g])
      ) u_reg (
        .clk      (clk),
        .rst      (rst),
        .wr_en    (wr),
        .op       (op_sel),
        .wdata    (wd),
        .value_ff (regs[g])
      );
    end
  endgenerate

  // The stop bus carries exactly one word per disable register.
  if ($bits(module_clock_stop_bit) != NREG * 32) begin : g_width_check
    $error("stop bus width does not match the register count");
  end

  // The lock field must lie inside one bus word.
  if (`LOCK_BIT_POS > 31) begin : g_lock_pos_check
    $error("lock bit position lies outside the bus word");
  end

  logic [31:0] nxt_rdata;
  always_comb begin
    nxt_rdata = `UNMAPPED_READ;
    for (int i = 0; i < NREG; i++) begin
      if (address == BASES[i]) begin
        nxt_rdata = regs[i];
      end
    end
    if (cfg_sel) begin
      nxt_rdata = ctrl_word(lock_ff);
    end
  end

  // Read data is caught when the request is taken and stands through the answer cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      readdata <= `UNMAPPED_READ;
    end else if (read && take) begin
      readdata <= nxt_rdata;
    end
  end

  // Each high bit stops that module's clock and its registers with it.
  logic [191:0] nxt_stop_bits;
  assign nxt_stop_bits = {regs[5], regs[4], regs[3], regs[2], regs[1], regs[0]};
  always_ff @(posedge clk) begin
    if (rst) begin
      module_clock_stop_bit <= '0;
    end else begin
      module_clock_stop_bit <= nxt_stop_bits;
    end
  end

  // The pin select logic watches this registered copy of lock_ff, so it freezes one cycle after the bank.
  always_ff @(posedge clk) begin
    if (rst) begin
      disable_bank_write_lock <= 1'b0;
    end else begin
      disable_bank_write_lock <= lock_ff;
    end
  end
endmodule : clock_gate_bank
`default_nettype wire

// *** verification/clock_gate_chk.sv ***
// Port checker for the module clock-gate bank.
`timescale 1ns/1ps
`default_nettype none
`include "clock_gate_consts.svh"
module clock_gate_chk (
  input wire logic         clk,                     // Clock.
  input wire logic         rst,                     // Reset.
  input wire logic         config_word_three_in,    // Strap.
  input wire logic [15:0]  address,                 // Address.
  input wire logic         read,                    // Read.
  input wire logic         write,                   // Write.
  input wire logic [31:0]  writedata,               // Data.
  input wire logic [3:0]   byteenable,              // Lanes.
  input wire logic [31:0]  readdata,                // Read data.
  input wire logic         waitrequest,             // Wait.
  input wire logic [191:0] module_clock_stop_bit,   // Stops.
  input wire logic         disable_bank_write_lock  // Lock.
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic         lk = disable_bank_write_lock;
  wire logic [191:0] so = module_clock_stop_bit;
  wire logic [191:0] im = {`MISC_MODULE_MASK, `SERIAL_PORT_MASK, `TIMER_MASK,
                           `CAPTURE_COMPARE_MASK, `COMPARATOR_MASK, `ANALOG_BLOCK_MASK};
  wire logic         go = write && !waitrequest && !lk && byteenable == 4'hF;
  property p_ack; (read || write) && waitrequest |=> !waitrequest ##1 waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("late ack");
  property p_lock; lk && $past(lk) && write && !waitrequest && address != 16'hF200
    |=> $stable(so) [*2]; endproperty
  a_lock: assert property (p_lock) else $error("locked write changed bits");
  property p_one; lk && config_word_three_in && $past(config_word_three_in, 3) |=> lk; endproperty
  a_one: assert property (p_one) else $error("one-way lock cleared");
  property p_fall; $fell(lk) |-> !$past(config_word_three_in, 4); endproperty
  a_fall: assert property (p_fall) else $error("held lock fell");
  property p_rst; $fell(rst) |-> so == '0 && !lk; endproperty
  a_rst: assert property (p_rst) else $error("bad reset value");
  property p_mask; (so & ~im) == '0; endproperty
  a_mask: assert property (p_mask) else $error("unimplemented bit set");
  property p_set; go && address == 16'hF248 |-> ##2
    (so[31:0] & $past(writedata, 2) & im[31:0]) == ($past(writedata, 2) & im[31:0]); endproperty
  a_set: assert property (p_set) else $error("set alias failed");
  property p_clr; go && address == 16'hF244 |-> ##2 (so[31:0] & $past(writedata, 2)) == '0;
  endproperty
  a_clr: assert property (p_clr) else $error("clear alias failed");
endmodule : clock_gate_chk
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the module clock-gate bank.
`timescale 1ns/1ps
`default_nettype none
`include "clock_gate_consts.svh"
module tb;
  logic         clk, rst, strap, read, write, waitrequest, lock;
  logic [15:0]  address;
  logic [31:0]  writedata, readdata, q;
  logic [191:0] stop;
  logic [3:0]   be;
  int           fail_count, num_checks;
  localparam logic [31:0] MK [6] = '{`ANALOG_BLOCK_MASK, `COMPARATOR_MASK, `CAPTURE_COMPARE_MASK,
                                     `TIMER_MASK, `SERIAL_PORT_MASK, `MISC_MODULE_MASK};
  clock_gate_bank u_dut (.clk(clk), .rst(rst), .config_word_three_in(strap), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(be), .readdata(readdata),
    .waitrequest(waitrequest), .module_clock_stop_bit(stop), .disable_bank_write_lock(lock));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // The request is held until waitrequest is sampled low, whatever the latency.
  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : bus
  task automatic rd(input string nm, input logic [15:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    check(nm, q, exp);
  endtask : rd
  task automatic t_alias();
    for (int i = 0; i < 6; i++) begin
      rd("reset", 16'hF240 + 16'(i * 16), 32'h00000000);
      // Every peripheral here is idle with its on bit clear, so any disable bit may be set.
      bus(1'b1, 16'hF240 + 16'(i * 16), 32'hFFFFFFFF);
      rd("mask", 16'hF240 + 16'(i * 16), MK[i]);
      check("stop", stop[32 * i +: 32], MK[i]);
      bus(1'b1, 16'hF244 + 16'(i * 16), 32'hFFFFFFFF);
      rd("clear", 16'hF240 + 16'(i * 16), 32'h00000000);
    end
    bus(1'b1, 16'hF248, 32'h00001101);
    bus(1'b1, 16'hF244, 32'h00000001);
    rd("clr", 16'hF240, 32'h00001100);
    bus(1'b1, 16'hF24C, 32'h00001001);
    rd("inv", 16'hF240, 32'h00000101);
    be <= 4'h2;
    bus(1'b1, 16'hF240, 32'h00000000);
    be <= 4'hF;
    rd("lanes", 16'hF240, 32'h00000001);
    rd("unmapped", 16'hF2A0, 32'h00000000);
  endtask : t_alias
  task automatic t_lock();
    bus(1'b1, 16'hF200, 32'h00001000);
    check("lock", {31'h0, lock}, 32'h1);
    rd("ctrl", 16'hF200, 32'h00001000);
    bus(1'b1, 16'hF250, 32'h00000007);
    rd("locked", 16'hF250, 32'h00000000);
    bus(1'b1, 16'hF200, 32'h00000000);
    bus(1'b1, 16'hF250, 32'h00000007);
    rd("open", 16'hF250, 32'h00000007);
  endtask : t_lock
  task automatic t_oneway();
    strap <= 1'b1;
    bus(1'b1, 16'hF200, 32'h00001000);
    bus(1'b1, 16'hF200, 32'h00000000);
    check("held", {31'h0, lock}, 32'h1);
    bus(1'b1, 16'hF260, 32'h00000001);
    rd("frozen", 16'hF260, 32'h00000000);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    check("unlocked", {31'h0, lock}, 32'h0);
    rd("ctrl0", 16'hF200, 32'h00000000);
    bus(1'b1, 16'hF260, 32'h00000001);
    rd("reopen", 16'hF260, 32'h00000001);
  endtask : t_oneway
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  initial begin
    {rst, strap, read, write, address, writedata, fail_count, num_checks} = '0;
    be = 4'hF;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_alias();
    t_lock();
    t_oneway();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
endmodule : tb
bind clock_gate_bank clock_gate_chk u_chk (.clk(clk), .rst(rst), .address(address),
  .config_word_three_in(config_word_three_in), .read(read), .write(write), .readdata(readdata),
  .writedata(writedata), .byteenable(byteenable), .waitrequest(waitrequest),
  .module_clock_stop_bit(module_clock_stop_bit), .disable_bank_write_lock(disable_bank_write_lock));
`default_nettype wire
